// File: rtl/cfg_port_pkg.sv
// constants and carrier types for the serial configuration port block
// assumes one 100 MHz clock; serial pins are already synchronous to it
package cfg_port_pkg;

    // register space
    localparam int unsigned ADDR_W      = 13;
    localparam int unsigned REG_COUNT   = 563;
    localparam int unsigned FIFO_DEPTH  = 4;
    localparam int unsigned INSTR_LAST  = 15;
    localparam int unsigned BYTE_LAST   = 7;

    // register offsets
    localparam logic [12:0] A_PORT_CFG    = 13'h0000;
    localparam logic [12:0] A_READ_SEL    = 13'h0004;
    localparam logic [12:0] A_PLL_CFG     = 13'h0010;
    localparam logic [12:0] A_BLOCK_PD    = 13'h001C;
    localparam logic [12:0] A_LVPECL_BASE = 13'h00F0;
    localparam logic [12:0] A_LVDS_BASE   = 13'h0140;
    localparam logic [12:0] A_DIST_CFG    = 13'h0230;
    localparam logic [12:0] A_UPDATE      = 13'h0232;

    // field positions
    localparam int unsigned B_READ_OUT_SEL = 0;
    localparam int unsigned B_LSB_FIRST    = 1;
    localparam int unsigned B_SOFT_RST_LO  = 2;
    localparam int unsigned B_SOFT_RST_HI  = 5;
    localparam int unsigned B_READ_ACTIVE  = 0;
    localparam int unsigned B_DIST_PD      = 1;
    localparam int unsigned B_UPDATE       = 0;
    localparam int unsigned B_CLK_IN_PD    = 0;
    localparam int unsigned B_REF_A_PD     = 1;
    localparam int unsigned B_REF_B_PD     = 2;
    localparam int unsigned B_VCO_PD       = 3;
    localparam int unsigned B_LVDS_PD      = 0;

    // values after reset
    localparam logic [7:0] PORT_CFG_RESET = 8'h18;
    localparam logic [7:0] OTHER_RESET    = 8'h00;

    // encodings
    localparam logic [1:0] PLL_NORMAL       = 2'h0;
    localparam logic [1:0] PLL_ASYNC_PD     = 2'h1;
    localparam logic [1:0] PLL_SYNC_PD      = 2'h3;
    localparam logic [1:0] LVPECL_NORMAL    = 2'h0;
    localparam logic [1:0] LVPECL_SAFE_OFF  = 2'h2;
    localparam logic [1:0] LVPECL_TOTAL_OFF = 2'h3;
    localparam logic [1:0] LEN_STREAM       = 2'h3;

    typedef struct packed {
        logic       pll_pd;
        logic       vco_pd;
        logic       clk_in_pd;
        logic       ref_a_pd;
        logic       ref_b_pd;
        logic       divider_pd;
        logic       dist_pd;
        logic [3:0] lvds_pd;
        logic [7:0] lvpecl_mode;
    } power_ctrl_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0]  data;
    } wr_word_t;

endpackage

// File: rtl/cfg_port.sv
// serial configuration port with reset and power-down control, plus its write fifo
// assumes serial pins synchronous to clk; sclk well below clk/4
//
// Functional notes
// - power-on and pin resets load all defaults, soft reset all but register 0, active at once
// - power-on reset ends with output sync request
// - low reset pin hard-resets registers asynchronously
// - soft reset while bits 2 and 5 set
// - soft reset bits act without update command
// - sleep pin low sleeps, wakes with current settings
// - sleep: pll, vco, clock input, dividers and lvds off (refs and dist bias as set), lvpecl held safe-off
// - serial port keeps working during sleep
// - wake needs no calibration; host syncs
// - pll mode field; async mode powers down immediately
// - sync pll power-down waits charge pump event
// - distribution bias off when bit set
// - lvpecl two-bit power-down mode passed through
// - per-output and per-block power-down bits
// - sample on sclk rise, launch on fall
// - read data on shared or separate pin
// - chip select high tristates both data pins
// - short transfers may stall at byte boundaries
// - abort by finishing or short fragment
// - non-boundary chip select rise resets port
// - streaming steps address until chip select rises or the top register is written
// - 16-bit instruction: rw, length, address
// - msb-first decrements, lsb-first increments address
// - update bit copies buffer to active registers
`timescale 1ns/1ns

module cfg_wr_fifo #(
    parameter int unsigned WIDTH = 21,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW:0] wr_ptr;
        logic [PW:0] rd_ptr;
    } fifo_state_t;

    logic [WIDTH-1:0] store [DEPTH];
    fifo_state_t      s_reg;
    fifo_state_t      s_next;
    logic             push;
    logic             pop;

    assign out_valid = s_reg.wr_ptr != s_reg.rd_ptr;
    assign in_ready  = (s_reg.wr_ptr[PW-1:0] != s_reg.rd_ptr[PW-1:0])
                       || (s_reg.wr_ptr[PW] == s_reg.rd_ptr[PW]);
    assign out_data  = store[s_reg.rd_ptr[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // storage carries no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            store[s_reg.wr_ptr[PW-1:0]] <= in_data;
        end
    end
endmodule

module cfg_port (
    // clock and resets
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     hard_reset_n,
    // power control inputs
    input  wire logic                     chip_sleep_n,
    input  wire logic                     cp_event,
    // serial port
    input  wire logic                     sclk,
    input  wire logic                     cs_n,
    input  wire logic                     sdio_in,
    output logic                          sdio_out,
    output logic                          sdio_oe_n,
    output logic                          serial_read_out,
    output logic                          read_out_oe_n,
    // controls toward the analog sections
    output cfg_port_pkg::power_ctrl_t     power,
    output logic                          output_sync_req,
    output logic                          write_dropped
);
    import cfg_port_pkg::*;

    typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [3:0]  cnt;
        logic [15:0] instr;
        logic        rw;
        logic        stream;
        logic [1:0]  bytes_left;
        logic [12:0] addr;
        logic [7:0]  dshift;
        logic [7:0]  rd_shift;
        logic        out_bit;
        logic        sclk_prev;
        logic        cs_prev;
        logic        wr_valid;
        wr_word_t    wr_word;
        logic        update_pending;
        logic        started;
        logic        soft_prev;
        logic        sync_req;
        logic        dropped;
        power_ctrl_t power;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;
    logic [7:0]  buf_mem [REG_COUNT];
    logic [7:0]  act_mem [REG_COUNT];
    logic        arst;
    logic        sleep;
    logic        soft_active;
    logic        lsb_first;
    logic        read_sep;
    logic        rise;
    logic        fall;
    logic        cs_rise;
    logic        direct_wr;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        drain_ready;
    wr_word_t    fifo_out;
    logic        update_go;
    logic        reading;

    function automatic logic [7:0] def_val(input int unsigned a);
        return (a == 0) ? PORT_CFG_RESET : OTHER_RESET;
    endfunction

    function automatic logic [15:0] shift16(input logic [15:0] v, input logic b, input logic lsb);
        return lsb ? {b, v[15:1]} : {v[14:0], b};
    endfunction

    function automatic logic [7:0] shift8(input logic [7:0] v, input logic b, input logic lsb);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
        if (lsb) begin
            return a + 13'h0001;
        end
        return (a == 13'h0000) ? A_UPDATE : a - 13'h0001;
    endfunction

    function automatic logic [7:0] read_reg(input logic [12:0] a, input logic from_act);
        if (int'(a) >= REG_COUNT) begin
            return 8'h00;
        end
        return from_act ? act_mem[int'(a)] : buf_mem[int'(a)];
    endfunction

    // pin reset joins power-on reset; a glitch on the pin resets the part
    assign arst        = rst || !hard_reset_n;
    assign sleep       = !chip_sleep_n;
    assign soft_active = buf_mem[0][B_SOFT_RST_LO] && buf_mem[0][B_SOFT_RST_HI];
    assign lsb_first   = buf_mem[0][B_LSB_FIRST];
    assign read_sep    = buf_mem[0][B_READ_OUT_SEL];
    // port logic is never gated by sleep
    assign rise        = !s_reg.sclk_prev && sclk && !cs_n;
    assign fall        = s_reg.sclk_prev && !sclk && !cs_n;
    assign cs_rise     = cs_n && !s_reg.cs_prev;
    assign direct_wr   = s_reg.wr_valid && (s_reg.wr_word.addr == A_PORT_CFG);
    assign drain_ready = !soft_active;
    assign update_go   = s_reg.update_pending && !fifo_out_valid;

    cfg_wr_fifo #(
        .WIDTH ($bits(wr_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_cfg_wr_fifo (
        .clk       (clk),
        .rst       (arst),
        .in_valid  (s_reg.wr_valid && !direct_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (s_reg.wr_word),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out)
    );

    always_comb begin
        logic [12:0] na;
        logic [1:0]  mode;
        logic        last;
        na         = '0;
        mode       = act_mem[int'(A_PLL_CFG)][1:0];
        last       = 1'b0;
        s_next     = s_reg;
        s_next.sclk_prev = sclk;
        s_next.cs_prev   = cs_n;
        s_next.wr_valid  = 1'b0;
        s_next.sync_req  = 1'b0;
        s_next.started   = 1'b1;
        s_next.soft_prev = soft_active;
        s_next.dropped   = s_reg.wr_valid && !direct_wr && !fifo_in_ready;
        if (rise) begin
            unique case (s_reg.phase)
                PH_INSTR: begin
                    s_next.instr = shift16(s_reg.instr, sdio_in, lsb_first);
                    s_next.cnt   = s_reg.cnt + 4'h1;
                    if (s_reg.cnt == 4'(INSTR_LAST)) begin
                        s_next.rw         = s_next.instr[15];
                        s_next.stream     = s_next.instr[14:13] == LEN_STREAM;
                        s_next.bytes_left = s_next.instr[14:13];
                        s_next.addr       = s_next.instr[12:0];
                        s_next.rd_shift   = read_reg(s_next.instr[12:0],
                                                     buf_mem[int'(A_READ_SEL)][B_READ_ACTIVE]);
                        s_next.phase      = PH_DATA;
                        s_next.cnt        = 4'h0;
                    end
                end
                PH_DATA: begin
                    s_next.dshift = shift8(s_reg.dshift, sdio_in, lsb_first);
                    s_next.cnt    = s_reg.cnt + 4'h1;
                    if (s_reg.cnt == 4'(BYTE_LAST)) begin
                        s_next.cnt = 4'h0;
                        if (!s_reg.rw) begin
                            s_next.wr_valid     = 1'b1;
                            s_next.wr_word.addr = s_reg.addr;
                            s_next.wr_word.data = s_next.dshift;
                        end
                        // streaming stops after the top register either way
                        last = s_reg.stream ? (s_reg.addr == A_UPDATE)
                                            : (s_reg.bytes_left == 2'h0);
                        na   = step_addr(s_reg.addr, lsb_first);
                        if (last) begin
                            s_next.phase = PH_DONE;
                        end else begin
                            s_next.addr       = na;
                            s_next.bytes_left = s_reg.bytes_left - 2'h1;
                            s_next.rd_shift   = read_reg(na,
                                                         buf_mem[int'(A_READ_SEL)][B_READ_ACTIVE]);
                        end
                    end
                end
                PH_DONE: begin
                end
            endcase
        end
        if (fall && s_reg.phase == PH_DATA && s_reg.rw) begin
            s_next.out_bit  = lsb_first ? s_reg.rd_shift[0] : s_reg.rd_shift[7];
            s_next.rd_shift = lsb_first ? {1'b0, s_reg.rd_shift[7:1]}
                                        : {s_reg.rd_shift[6:0], 1'b0};
        end
        // a boundary rise mid-instruction or in short-transfer data stalls; anything else ends it
        if (cs_rise) begin
            if (s_reg.cnt[2:0] != 3'h0 || s_reg.phase == PH_DONE
                || (s_reg.phase == PH_DATA && s_reg.stream)) begin
                s_next.phase = PH_INSTR;
                s_next.cnt   = 4'h0;
            end
        end
        if (fifo_out_valid && drain_ready && fifo_out.addr == A_UPDATE
            && fifo_out.data[B_UPDATE]) begin
            s_next.update_pending = 1'b1;
        end else if (update_go) begin
            s_next.update_pending = 1'b0;
        end
        // sync after power-on and after soft reset; wake from sleep does none
        s_next.sync_req = !s_reg.started || (s_reg.soft_prev && !soft_active);
        s_next.power.pll_pd = sleep || mode == PLL_ASYNC_PD
                              || (mode == PLL_SYNC_PD && (s_reg.power.pll_pd || cp_event));
        s_next.power.vco_pd     = sleep || act_mem[int'(A_BLOCK_PD)][B_VCO_PD];
        s_next.power.clk_in_pd  = sleep || act_mem[int'(A_BLOCK_PD)][B_CLK_IN_PD];
        s_next.power.ref_a_pd   = act_mem[int'(A_BLOCK_PD)][B_REF_A_PD];
        s_next.power.ref_b_pd   = act_mem[int'(A_BLOCK_PD)][B_REF_B_PD];
        s_next.power.dist_pd    = act_mem[int'(A_DIST_CFG)][B_DIST_PD];
        s_next.power.divider_pd = sleep || s_next.power.dist_pd;
        for (int i = 0; i < 4; i++) begin
            s_next.power.lvds_pd[i] = sleep
                                      || act_mem[int'(A_LVDS_BASE) + i][B_LVDS_PD];
            s_next.power.lvpecl_mode[2*i +: 2] = sleep ? LVPECL_SAFE_OFF
                                                 : act_mem[int'(A_LVPECL_BASE) + i][1:0];
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            s_reg       <= '0;
            s_reg.power <= '1;
            s_reg.cs_prev <= 1'b1; // idle select is high; no false rise after reset
        end else begin
            s_reg <= s_next;
        end
    end

    // both register copies; resets write defaults straight into the active set
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                buf_mem[i] <= def_val(i);
                act_mem[i] <= def_val(i);
            end
        end else begin
            if (soft_active) begin
                for (int i = 1; i < REG_COUNT; i++) begin
                    buf_mem[i] <= def_val(i);
                    act_mem[i] <= def_val(i);
                end
            end else begin
                if (update_go) begin
                    for (int i = 0; i < REG_COUNT; i++) begin
                        act_mem[i] <= buf_mem[i];
                    end
                end
                if (fifo_out_valid && int'(fifo_out.addr) < REG_COUNT) begin
                    buf_mem[int'(fifo_out.addr)] <= (fifo_out.addr == A_UPDATE)
                        ? (fifo_out.data & 8'hFE) : fifo_out.data;
                end
            end
            // port configuration takes effect as soon as the byte lands
            if (direct_wr) begin
                buf_mem[0] <= s_reg.wr_word.data;
                act_mem[0] <= s_reg.wr_word.data;
            end
        end
    end

    assign reading         = !cs_n && s_reg.phase == PH_DATA && s_reg.rw;
    assign sdio_out        = s_reg.out_bit;
    assign serial_read_out = s_reg.out_bit;
    assign sdio_oe_n       = !(reading && !read_sep);
    assign read_out_oe_n   = !(reading && read_sep);
    assign power           = s_reg.power;
    assign output_sync_req = s_reg.sync_req;
    assign write_dropped   = s_reg.dropped;

    default clocking dc @(posedge clk); endclocking
    default disable iff (arst);

    sleep_off_a: assert property (sleep |=> power.pll_pd && power.vco_pd
        && power.lvds_pd == 4'hF && power.divider_pd) else $error("sleep left a block on");
    lvpecl_safe_a: assert property (sleep |=> power.lvpecl_mode == 8'hAA)
        else $error("lvpecl not safe-off in sleep");
    dist_bias_a: assert property (act_mem[int'(A_DIST_CFG)][B_DIST_PD] |=> power.dist_pd)
        else $error("distribution bias not removed");
    cs_tristate_a: assert property (cs_n |-> sdio_oe_n && read_out_oe_n)
        else $error("data pin driven with chip select high");
    por_sync_a: assert property (s_reg.started && !$past(s_reg.started) |-> output_sync_req)
        else $error("no sync request after reset");
    soft_default_a: assert property (soft_active |=> act_mem[int'(A_PLL_CFG)] == OTHER_RESET)
        else $error("soft reset did not restore defaults");
    frag_abort_a: assert property (cs_rise && s_reg.cnt[2:0] != 3'h0
        |=> s_reg.phase == PH_INSTR && s_reg.cnt == 4'h0) else $error("fragment not discarded");
    async_pll_a: assert property (act_mem[int'(A_PLL_CFG)][1:0] == PLL_ASYNC_PD
        |=> power.pll_pd) else $error("async pll power-down late");
    sync_pll_a: assert property (act_mem[int'(A_PLL_CFG)][1:0] == PLL_SYNC_PD && !sleep
        && !power.pll_pd && !cp_event |=> !power.pll_pd) else $error("pll off before pump event");
    read_pin_a: assert property (reading && read_sep |-> sdio_oe_n && !read_out_oe_n)
        else $error("read data on wrong pin");
    update_copy_a: assert property (update_go ##1 !soft_active
        |-> act_mem[int'(A_DIST_CFG)] == $past(buf_mem[int'(A_DIST_CFG)])) else $error("no copy");

    write_done_c: cover property (s_reg.wr_valid ##[1:20] update_go);
    read_done_c: cover property (reading ##[1:200] s_reg.phase == PH_DONE);
    stall_c: cover property (cs_rise && s_reg.phase == PH_DATA && !s_reg.stream ##[1:50] rise);
    sleep_wake_c: cover property (sleep ##[1:100] !sleep);
endmodule

// File: bench/host_model.sv
// serial master standing in for the host controller
// assumes clk at 100 MHz; sclk stands low and cs_n high outside frames
`timescale 1ns/1ns
module host_model (
    input  wire logic clk,
    input  wire logic rd_line,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // four clk each phase keeps well above the two-clk minimum
    task automatic bit_x(input logic b, output logic q);
        @(posedge clk) mosi <= b;
        repeat (3) @(posedge clk);
        q = rd_line;
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
    endtask
    task automatic xfer(input logic [15:0] ins, input int n, input logic [31:0] d,
                        input logic stall, output logic [31:0] q);
        logic b;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) bit_x(ins[i], b);
        if (stall) begin
            @(posedge clk) cs_n <= 1'b1;
            repeat (6) @(posedge clk);
            cs_n <= 1'b0;
        end
        q = '0;
        for (int i = 8 * n - 1; i >= 0; i--) begin
            // a released line toggles so a stale level never reads as data
            bit_x(ins[15] ? ~mosi : d[i], b);
            q = {q[30:0], b};
        end
        @(posedge clk) cs_n <= 1'b1;
    endtask
    task automatic frag(input int n);
        logic b;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 0; i < n; i++) bit_x(1'b1, b);
        @(posedge clk) cs_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// File: bench/cfg_port_tb_top.sv
// self-checking bench for cfg_port with the host model on its serial side
// assumes cfg_port_pkg compiled first; one 100 MHz clock
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cfg_port_tb_top;
    import cfg_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hard_reset_n = 1'b1;
    logic        chip_sleep_n = 1'b1;
    logic        cp_event = 1'b0;
    logic        sclk, cs_n, mosi, sdio_in, sdio_out, sdio_oe_n;
    logic        ro, ro_oe_n, sync_req, rd_line, dropped;
    power_ctrl_t pw;
    logic [31:0] q;
    int          num_errors = 0;
    int          checks = 0;
    int          n_sync = 0;
    int          n_io = 0;
    int          n_so = 0;
    int          n_drop = 0;
    always #5 clk = ~clk;
    assign sdio_in = sdio_oe_n ? mosi : sdio_out;
    assign rd_line = !sdio_oe_n ? sdio_out : !ro_oe_n ? ro : ~mosi;
    always @(posedge clk) begin
        n_sync += (sync_req === 1'b1);
        n_io += (sdio_oe_n === 1'b0);
        n_so += (ro_oe_n === 1'b0);
        n_drop += (dropped === 1'b1);
    end
    cfg_port u_cfg_port (.clk(clk), .rst(rst), .hard_reset_n(hard_reset_n),
        .chip_sleep_n(chip_sleep_n), .cp_event(cp_event), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_read_out(ro), .read_out_oe_n(ro_oe_n), .power(pw),
        .output_sync_req(sync_req), .write_dropped(dropped));
    host_model u_host_model (.clk(clk), .rd_line(rd_line), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi));
    // settling covers word register, fifo hop, drain and update copy
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        u_host_model.xfer({3'h0, a}, 1, {24'h0, d}, 1'b0, q);
        repeat (8) @(posedge clk);
    endtask
    task automatic upd();
        wr(A_UPDATE, 8'h01);
    endtask
    task automatic rd(input logic [12:0] a);
        u_host_model.xfer({3'h4, a}, 1, 32'h0, 1'b0, q);
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset();
        int so0;
        so0 = n_so;
        `CHK("power", 19'h0, pw)
        `CHK("sync", 1, n_sync)
        `CHK("sdio_oe_n", 1'b1, sdio_oe_n)
        `CHK("sdo_oe_n", 1'b1, ro_oe_n)
        rd(A_PORT_CFG);
        `CHK("port_cfg", PORT_CFG_RESET, q[7:0])
        `CHK("sdo idle", so0, n_so)
        $display("t_reset done");
    endtask
    task automatic t_update();
        wr(A_BLOCK_PD, 8'h0F);
        `CHK("buffered", 1'b0, pw.clk_in_pd)
        upd();
        `CHK("blocks", 4'hF, ({pw.vco_pd, pw.clk_in_pd, pw.ref_a_pd, pw.ref_b_pd}))
        $display("t_update done");
    endtask
    task automatic t_pll();
        wr(A_PLL_CFG, {6'h0, PLL_SYNC_PD});
        upd();
        `CHK("pll sync wait", 1'b0, pw.pll_pd)
        cp_event <= 1'b1;
        @(posedge clk) cp_event <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("pll sync off", 1'b1, pw.pll_pd)
        wr(A_PLL_CFG, {6'h0, PLL_NORMAL});
        upd();
        `CHK("pll on", 1'b0, pw.pll_pd)
        wr(A_PLL_CFG, {6'h0, PLL_ASYNC_PD});
        upd();
        `CHK("pll async", 1'b1, pw.pll_pd)
        $display("t_pll done");
    endtask
    task automatic t_multi();
        u_host_model.xfer({3'h1, A_LVPECL_BASE + 13'h1}, 2, 32'h0203, 1'b0, q);
        repeat (8) @(posedge clk);
        u_host_model.xfer({3'h0, A_DIST_CFG}, 1, 32'h02, 1'b1, q);
        repeat (8) @(posedge clk);
        upd();
        `CHK("lvpecl", 8'h0B, pw.lvpecl_mode)
        `CHK("dist_pd", 1'b1, pw.dist_pd)
        $display("t_multi done");
    endtask
    task automatic t_frag();
        u_host_model.frag(5);
        u_host_model.xfer({3'h3, A_LVDS_BASE + 13'h3}, 4, 32'h1, 1'b0, q);
        repeat (8) @(posedge clk);
        upd();
        `CHK("lvds", 4'h1, pw.lvds_pd)
        $display("t_frag done");
    endtask
    task automatic t_sleep();
        int s0;
        s0 = n_sync;
        chip_sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("sleep", 4'hF, ({pw.pll_pd, pw.vco_pd, pw.clk_in_pd, pw.divider_pd}))
        `CHK("sleep lvds", 4'hF, pw.lvds_pd)
        `CHK("sleep lvpecl", 8'hAA, pw.lvpecl_mode)
        wr(A_LVDS_BASE + 13'h2, 8'h01);
        upd();
        rd(A_LVDS_BASE + 13'h2);
        `CHK("sleep read", 8'h01, q[7:0])
        chip_sleep_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("wake lvds", 4'h5, pw.lvds_pd)
        `CHK("wake lvpecl", 8'h0B, pw.lvpecl_mode)
        `CHK("wake sync", s0, n_sync)
        $display("t_sleep done");
    endtask
    task automatic t_unidir();
        int io0;
        wr(A_PORT_CFG, 8'h99);
        io0 = n_io;
        rd(A_PORT_CFG);
        `CHK("sdo data", 8'h99, q[7:0])
        `CHK("sdio quiet", io0, n_io)
        // lsb first; the mirrored config byte reads the same in either order
        wr(A_PORT_CFG, 8'h5A);
        // bit-reversed instruction and data: two bytes from 0x0F0 upward
        u_host_model.xfer(16'h0F04, 2, 32'h40C0, 1'b0, q);
        wr(A_PORT_CFG, PORT_CFG_RESET);
        upd();
        `CHK("lsb first", 8'h0E, pw.lvpecl_mode)
        $display("t_unidir done");
    endtask
    task automatic t_soft();
        int s0;
        wr(A_PORT_CFG, 8'h3C);
        `CHK("soft dist", 1'b0, pw.dist_pd)
        `CHK("soft lvds", 4'h0, pw.lvds_pd)
        // the fifo stalls during soft reset, so the fifth buffered byte is lost
        u_host_model.xfer({3'h3, A_LVDS_BASE + 13'h3}, 4, 32'h0, 1'b0, q);
        wr(A_LVDS_BASE, 8'h00);
        `CHK("dropped", 1, n_drop)
        s0 = n_sync;
        wr(A_PORT_CFG, PORT_CFG_RESET);
        `CHK("soft sync", s0 + 1, n_sync)
        wr(A_BLOCK_PD, 8'h01);
        upd();
        hard_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        hard_reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("hard power", 19'h0, pw)
        rd(A_BLOCK_PD);
        `CHK("hard reg", 8'h00, q[7:0])
        $display("t_soft done");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_update();
        t_pll();
        t_multi();
        t_frag();
        t_sleep();
        t_unidir();
        t_soft();
        print_verdict();
    end
    // roughly four times the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
